// ===== rtl/smc_pkg.sv
// Constants, carrier types and states shared by the sleep-mode controller.
package smc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock rate and timing.
  localparam int unsigned CLK_FREQ_MHZ = 125;
  localparam int unsigned BOD_WAKE_US  = 60;
  // Approximate figure; rounding up keeps the detector settled before resume.
  localparam int unsigned BOD_WAKE_CYCLES = BOD_WAKE_US * CLK_FREQ_MHZ;
  // Start-up delay normally set by fuses; plain default, not a device figure.
  localparam int unsigned FUSE_STARTUP_CYCLES = 16;

  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] STBY_WAKE_CYCLES = 13'h0006;
  localparam logic [CNT_W-1:0] HALT_CYCLES      = 13'h0004;
  localparam logic [CNT_W-1:0] RUN_WAKE_CYCLES  = 13'h0001;
  localparam logic [2:0]       BROWNOUT_SLEEP_OFF_WINDOW_CYCLES = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep kind select codes.
  localparam logic [2:0] KIND_IDLE  = 3'h0;
  localparam logic [2:0] KIND_CONV  = 3'h1;
  localparam logic [2:0] KIND_PDOWN = 3'h2;
  localparam logic [2:0] KIND_PSAVE = 3'h3;
  localparam logic [2:0] KIND_STBY  = 3'h6;
  localparam logic [2:0] KIND_XSTBY = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic BROWNOUT_SLEEP_OFF_RESET    = 1'b0;
  localparam logic [4:0] CLK_ALL_ON = 5'h1f;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic core_clock;
    logic program_mem_clock;
    logic io_clock;
    logic converter_clock;
    logic async_timer_clock;
  } smc_clk_type;

  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic pin_change_irq;
    logic two_wire_match;
    logic timer2_irq;
    logic self_program_ready;
    logic converter_done;
    logic watchdog_irq;
    logic other_io_irq;
  } smc_wake_type;

  typedef struct packed {
    logic ext_reset;
    logic watchdog_reset;
    logic brownout_reset;
  } smc_rst_src_type;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} smc_state_type;

endpackage

// ===== rtl/smc_sync2.sv
// Two-flop synchroniser for wake and reset sources arriving from outside.
`timescale 1ns/10ps
module smc_sync2
  import smc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  ////////////////////////////////////////////////////////////////////////////
  // The first stage feeds only the second stage.
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_comb begin
      next_meta[g] = i_async[g];
      next_sync[g] = meta[g];
    end

    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        meta[g]   <= 1'b0;
        o_sync[g] <= 1'b0;
      end else begin
        meta[g]   <= next_meta[g];
        o_sync[g] <= next_sync[g];
      end
    end
  end

endmodule // smc_sync2

// ===== rtl/smc_wake_timer.sv
// Down-counter that times the start-up and halt phases of a wake-up.
`timescale 1ns/10ps
module smc_wake_timer
  import smc_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_value,
  output logic                  o_done
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (i_load) begin
      next_cnt = i_value;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // A load of N keeps the caller in its phase for exactly N cycles.
  assign o_done = (cnt == 13'h0001);

endmodule // smc_wake_timer

// ===== rtl/smc_sleep_ctrl.sv
// Sleep-mode controller: entry, clock gating, wake-up sequencing, detector off.
`timescale 1ns/10ps
//
// Contract
// - Sleep only when sleep_enable is 1 and the sleep instruction executes.
// - Kind 000 enters Idle; core and program memory clocks stop.
// - Idle keeps peripherals running and wakes on any enabled interrupt.
// - Kind 001 enters converter mode; io, core, program clocks stop.
// - Converter mode keeps converter, external irq, two-wire, timer, watchdog.
// - Entering converter mode starts a conversion when the converter is enabled.
// - Converter mode wakes only on its listed interrupt and reset events.
// - Deep modes stop system clocks; oscillators follow the mode table.
// - Outside Idle the two external inputs wake only when level-triggered.
// - Timer oscillator and wake need asynchronous timer clocking; Idle and power-save still wake on timer2 without it.
// - Interrupt wake holds the core four cycles after start-up, then services.
// - Register file and memory contents survive sleep unchanged.
// - Reset during sleep wakes the device to the reset vector.
// - brownout_sleep_off at 1 turns the detector off; reset value is 0.
// - Detector may be turned off only in the four deep modes.
// - Detector turns off as the sleep state is entered, not before.
// - Every wake-up re-enables a detector turned off for sleep.
// - Wake-up with detector off is stretched to about 60 us.
// - Codes 010, 011, 110, 111 select the four deep modes.
// - Standby modes complete wake-up within six cycles.
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned BOD_WAKE_CYCLES_P = BOD_WAKE_CYCLES,
  parameter int unsigned STARTUP_CYCLES_P  = FUSE_STARTUP_CYCLES
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_sleep_exec,
  input  wire logic            i_sleep_enable,
  input  wire logic [2:0]      i_sleep_kind_select,
  input  wire logic [1:0]      i_ext_irq_level,
  input  wire logic            i_timer_async,
  input  wire logic            i_converter_enabled,
  input  wire logic            i_brownout_sleep_off_unlock,
  input  wire logic            i_brownout_sleep_off_wr,
  input  wire logic            i_brownout_sleep_off_data,
  input  wire smc_wake_type    i_wake_src,
  input  wire smc_rst_src_type i_rst_src,
  output smc_clk_type          o_clk_en,
  output logic                 o_main_osc_en,
  output logic                 o_timer_osc_en,
  output logic                 o_brownout_det_en,
  output logic                 o_brownout_sleep_off,
  output logic                 o_sleeping,
  output logic                 o_core_hold,
  output logic                 o_converter_start,
  output logic                 o_irq_service,
  output logic                 o_restart_vector
);

  localparam int unsigned SYNC_W = $bits(smc_wake_type) + $bits(smc_rst_src_type);

  ////////////////////////////////////////////////////////////////////////////
  // Decoders.
  function automatic logic kind_valid(input logic [2:0] k);
    // Reserved codes fall through as invalid.
    return (k == KIND_IDLE) || (k == KIND_CONV) || (k == KIND_PDOWN) ||
           (k == KIND_PSAVE) || (k == KIND_STBY) || (k == KIND_XSTBY);
  endfunction

  function automatic logic is_deep(input logic [2:0] k);
    return (k == KIND_PDOWN) || (k == KIND_PSAVE) || (k == KIND_STBY) ||
           (k == KIND_XSTBY);
  endfunction

  function automatic smc_clk_type clocks_for(input logic [2:0] k, input logic async_t);
    smc_clk_type c;
    c = '0;
    case (k)
      KIND_IDLE: begin
        c.io_clock          = 1'b1;
        c.converter_clock   = 1'b1;
        c.async_timer_clock = 1'b1;
      end
      KIND_CONV: begin
        c.converter_clock   = 1'b1;
        c.async_timer_clock = async_t;
      end
      KIND_PSAVE: begin
        c.async_timer_clock = 1'b1;
      end
      KIND_XSTBY: begin
        c.async_timer_clock = async_t;
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction

  function automatic smc_wake_type wake_mask(input logic [2:0] k, input logic [1:0] lvl,
                                             input logic async_t);
    smc_wake_type m;
    m = '0;
    m.ext_irq_zero   = lvl[0];
    m.ext_irq_one    = lvl[1];
    m.pin_change_irq = 1'b1;
    m.two_wire_match = 1'b1;
    m.watchdog_irq   = 1'b1;
    case (k)
      KIND_IDLE: begin
        m = '1;
      end
      KIND_CONV: begin
        m.timer2_irq         = async_t;
        m.self_program_ready = 1'b1;
        m.converter_done     = 1'b1;
      end
      KIND_PSAVE: begin
        m.timer2_irq = 1'b1;
      end
      KIND_XSTBY: begin
        m.timer2_irq = async_t;
      end
      default: begin
        m.timer2_irq = 1'b0;
      end
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised wake sources.
  smc_wake_type    wake_sync;
  smc_rst_src_type rst_sync;

  smc_sync2 #(.W(SYNC_W)) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_wake_src, i_rst_src}),
    .o_sync  ({wake_sync, rst_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Timed unlock for brownout_sleep_off.
  logic [2:0] brownout_sleep_off_win;
  logic [2:0] next_brownout_sleep_off_win;
  logic       next_brownout_sleep_off;

  always_comb begin
    next_brownout_sleep_off_win = brownout_sleep_off_win;
    next_brownout_sleep_off     = o_brownout_sleep_off;
    if (i_brownout_sleep_off_wr && (brownout_sleep_off_win != 3'h0)) begin
      next_brownout_sleep_off     = i_brownout_sleep_off_data;
      next_brownout_sleep_off_win = 3'h0;
    end else if (i_brownout_sleep_off_unlock && (brownout_sleep_off_win == 3'h0)) begin
      next_brownout_sleep_off_win = BROWNOUT_SLEEP_OFF_WINDOW_CYCLES;
    end else if (brownout_sleep_off_win != 3'h0) begin
      next_brownout_sleep_off_win = brownout_sleep_off_win - 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      brownout_sleep_off_win             <= 3'h0;
      o_brownout_sleep_off <= BROWNOUT_SLEEP_OFF_RESET;
    end else begin
      brownout_sleep_off_win             <= next_brownout_sleep_off_win;
      o_brownout_sleep_off <= next_brownout_sleep_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencer.
  smc_state_type    state;
  smc_state_type    next_state;
  logic [2:0]       kind;
  logic [2:0]       next_kind;
  logic             bod_off;
  logic             next_bod_off;
  logic             reset_wake;
  logic             next_reset_wake;
  logic             next_conv_start;
  logic             next_irq_service;
  logic             next_restart;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_done;
  logic             irq_wake;
  logic             rst_wake;

  assign irq_wake = |(wake_sync & wake_mask(kind, i_ext_irq_level, i_timer_async));
  assign rst_wake = |rst_sync;

  always_comb begin
    next_state       = state;
    next_kind        = kind;
    next_bod_off     = bod_off;
    next_reset_wake  = reset_wake;
    next_conv_start  = 1'b0;
    next_irq_service = 1'b0;
    next_restart     = 1'b0;
    tmr_load         = 1'b0;
    tmr_value        = RUN_WAKE_CYCLES;
    case (state)
      ST_RUN: begin
        if (i_sleep_exec && i_sleep_enable && kind_valid(i_sleep_kind_select)) begin
          next_state   = ST_SLEEP;
          next_kind    = i_sleep_kind_select;
          next_bod_off = o_brownout_sleep_off && is_deep(i_sleep_kind_select);
          next_conv_start = i_converter_enabled && (i_sleep_kind_select == KIND_CONV);
        end
      end
      ST_SLEEP: begin
        if (rst_wake || irq_wake) begin
          next_state      = ST_START;
          next_reset_wake = rst_wake;
          tmr_load        = 1'b1;
          if (bod_off) begin
            tmr_value = CNT_W'(BOD_WAKE_CYCLES_P);
          end else if ((kind == KIND_STBY) || (kind == KIND_XSTBY)) begin
            tmr_value = STBY_WAKE_CYCLES;
          end else if (is_deep(kind)) begin
            tmr_value = CNT_W'(STARTUP_CYCLES_P);
          end
        end
      end
      ST_START: begin
        if (tmr_done) begin
          if (reset_wake) begin
            next_state   = ST_RUN;
            next_restart = 1'b1;
          end else begin
            next_state = ST_HALT;
            tmr_load   = 1'b1;
            tmr_value  = HALT_CYCLES;
          end
        end
      end
      ST_HALT: begin
        if (tmr_done) begin
          next_state       = ST_RUN;
          next_irq_service = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  smc_wake_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (tmr_load),
    .i_value (tmr_value),
    .o_done  (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, oscillator and detector controls follow the next state.
  smc_clk_type next_clk;
  logic        next_main_osc;
  logic        next_timer_osc;
  logic        next_bod_en;
  logic        gated;

  always_comb begin
    gated = (next_state == ST_SLEEP) || (next_state == ST_START);
    // clocks return only after start-up, from registered enables
    next_clk      = gated ? clocks_for(next_kind, i_timer_async) : smc_clk_type'(CLK_ALL_ON);
    next_main_osc = !gated || !is_deep(next_kind) ||
                    (next_kind == KIND_STBY) || (next_kind == KIND_XSTBY);
    next_timer_osc = i_timer_async &&
                     (!gated || (next_kind == KIND_IDLE) || (next_kind == KIND_CONV) ||
                      (next_kind == KIND_PSAVE) || (next_kind == KIND_XSTBY));
    next_bod_en = !((next_state == ST_SLEEP) && next_bod_off);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state             <= ST_RUN;
      kind              <= KIND_IDLE;
      bod_off           <= 1'b0;
      reset_wake        <= 1'b0;
      o_clk_en          <= CLK_ALL_ON;
      o_main_osc_en     <= 1'b1;
      o_timer_osc_en    <= 1'b0;
      o_brownout_det_en <= 1'b1;
      o_sleeping        <= 1'b0;
      o_core_hold       <= 1'b0;
      o_converter_start <= 1'b0;
      o_irq_service     <= 1'b0;
      o_restart_vector  <= 1'b0;
    end else begin
      state             <= next_state;
      kind              <= next_kind;
      bod_off           <= next_bod_off;
      reset_wake        <= next_reset_wake;
      o_clk_en          <= next_clk;
      o_main_osc_en     <= next_main_osc;
      o_timer_osc_en    <= next_timer_osc;
      o_brownout_det_en <= next_bod_en;
      o_sleeping        <= (next_state == ST_SLEEP);
      // the core is held, never cleared, so its storage survives
      o_core_hold       <= (next_state != ST_RUN);
      o_converter_start <= next_conv_start;
      o_irq_service     <= next_irq_service;
      o_restart_vector  <= next_restart;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  logic in_start;
  logic in_halt;
  assign in_start = (state == ST_START);
  assign in_halt  = (state == ST_HALT);

  sequence s_halt_then_service;
    o_core_hold [*4] ##1 (o_irq_service && !o_core_hold);
  endsequence

  sequence s_standby_wake;
    in_start [*6] ##1 in_halt;
  endsequence

  a_sleep_needs_enable: assert property (
    (state == ST_RUN && i_sleep_exec && !i_sleep_enable) |=> !o_sleeping)
    else $error("sleep entered without sleep enable");

  a_idle_clock_gates: assert property (
    (o_sleeping && kind == KIND_IDLE) |->
      (!o_clk_en.core_clock && !o_clk_en.program_mem_clock && o_clk_en.io_clock))
    else $error("idle clock gating wrong");

  a_reserved_kind_ignored: assert property (
    (state == ST_RUN && i_sleep_exec && !kind_valid(i_sleep_kind_select))
      |=> (state == ST_RUN && !o_core_hold))
    else $error("reserved sleep kind entered sleep");

  a_conv_auto_start: assert property (
    (state == ST_RUN && i_sleep_exec && i_sleep_enable && i_converter_enabled &&
     i_sleep_kind_select == KIND_CONV) |=> (o_converter_start && o_sleeping))
    else $error("conversion not started on converter-mode entry");

  a_bod_off_entry: assert property (
    $rose(o_sleeping) |-> (o_brownout_det_en == !bod_off))
    else $error("detector state wrong at sleep entry");

  a_bod_back_on: assert property (
    (o_sleeping ##1 !o_sleeping) |-> o_brownout_det_en)
    else $error("detector not re-enabled on wake");

  a_bod_deep_only: assert property (
    (o_sleeping && !is_deep(kind)) |-> o_brownout_det_en)
    else $error("detector turned off in a shallow mode");

  a_halt_four_cycles: assert property (
    $rose(in_halt) |-> s_halt_then_service)
    else $error("interrupt wake did not hold core four cycles");

  a_standby_six_cycles: assert property (
    ($rose(in_start) && !bod_off && !reset_wake &&
     (kind == KIND_STBY || kind == KIND_XSTBY)) |-> s_standby_wake)
    else $error("standby wake not six cycles");

  a_reset_to_vector: assert property (
    (in_start && reset_wake && tmr_done) |=> (o_restart_vector && !o_core_hold))
    else $error("reset wake did not restart at vector");

  a_core_gated_start: assert property (
    in_start |-> (!o_clk_en.core_clock && o_core_hold))
    else $error("core clock restarted before start-up expired");

endmodule // smc_sleep_ctrl

// ===== dv/smc_core_model.sv
// Model of the core that issues the sleep instruction and the detector-off writes.
`timescale 1ns/10ps
module smc_core_model (
  input  wire logic  i_clk,
  input  wire logic  i_core_hold,
  output logic       o_sleep_exec,
  output logic       o_sleep_enable,
  output logic [2:0] o_sleep_kind_select,
  output logic       o_brownout_sleep_off_unlock,
  output logic       o_brownout_sleep_off_wr,
  output logic       o_brownout_sleep_off_data
);
  initial begin
    o_sleep_exec = 1'b0;
    o_sleep_enable = 1'b0;
    o_sleep_kind_select = 3'h0;
    o_brownout_sleep_off_unlock = 1'b0;
    o_brownout_sleep_off_wr = 1'b0;
    o_brownout_sleep_off_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Enable, then execute.
  task automatic do_sleep(input logic [2:0] k, input logic en);
    int w;
    w = 0;
    // A held core cannot execute anything, so wait for it to run again.
    while (i_core_hold !== 1'b0 && w < 50) begin
      @(negedge i_clk);
      w++;
    end
    o_sleep_enable = en;
    o_sleep_kind_select = k;
    @(negedge i_clk);
    o_sleep_exec = 1'b1;
    @(negedge i_clk);
    o_sleep_exec = 1'b0;
    o_sleep_enable = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Unlock, then write.
  task automatic brownout_sleep_off_seq(input logic unl, input int gap, input logic d);
    if (unl) begin
      o_brownout_sleep_off_unlock = 1'b1;
      @(negedge i_clk);
      o_brownout_sleep_off_unlock = 1'b0;
      repeat (gap - 1) @(negedge i_clk);
    end
    o_brownout_sleep_off_wr = 1'b1;
    o_brownout_sleep_off_data = d;
    @(negedge i_clk);
    o_brownout_sleep_off_wr = 1'b0;
  endtask
endmodule // smc_core_model

// ===== dv/tb_top.sv
// Self-checking bench for the sleep-mode controller with a mode-table model.
`timescale 1ns/10ps
module tb_top
  import smc_pkg::*;
;
  localparam int BODP = 20;
  localparam int SUP  = 3;
  logic            i_clk;
  logic            i_rst_n;
  logic            i_sleep_exec;
  logic            i_sleep_enable;
  logic [2:0]      i_sleep_kind_select;
  logic [1:0]      i_ext_irq_level;
  logic            i_timer_async;
  logic            i_converter_enabled;
  logic            i_brownout_sleep_off_unlock;
  logic            i_brownout_sleep_off_wr;
  logic            i_brownout_sleep_off_data;
  smc_wake_type    i_wake_src;
  smc_rst_src_type i_rst_src;
  smc_clk_type     o_clk_en;
  logic            o_main_osc_en;
  logic            o_timer_osc_en;
  logic            o_brownout_det_en;
  logic            o_brownout_sleep_off;
  logic            o_sleeping;
  logic            o_core_hold;
  logic            o_converter_start;
  logic            o_irq_service;
  logic            o_restart_vector;
  int              err_total  = 0;
  int              num_checks = 0;
  logic [31:0]     seed       = 32'h0000005f;
  int              cnt;

  smc_sleep_ctrl #(.BOD_WAKE_CYCLES_P(BODP), .STARTUP_CYCLES_P(SUP)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sleep_exec(i_sleep_exec),
    .i_sleep_enable(i_sleep_enable), .i_sleep_kind_select(i_sleep_kind_select),
    .i_ext_irq_level(i_ext_irq_level), .i_timer_async(i_timer_async),
    .i_converter_enabled(i_converter_enabled), .i_brownout_sleep_off_unlock(i_brownout_sleep_off_unlock),
    .i_brownout_sleep_off_wr(i_brownout_sleep_off_wr), .i_brownout_sleep_off_data(i_brownout_sleep_off_data), .i_wake_src(i_wake_src),
    .i_rst_src(i_rst_src), .o_clk_en(o_clk_en), .o_main_osc_en(o_main_osc_en),
    .o_timer_osc_en(o_timer_osc_en), .o_brownout_det_en(o_brownout_det_en),
    .o_brownout_sleep_off(o_brownout_sleep_off), .o_sleeping(o_sleeping),
    .o_core_hold(o_core_hold), .o_converter_start(o_converter_start),
    .o_irq_service(o_irq_service), .o_restart_vector(o_restart_vector));

  smc_core_model i_core (
    .i_clk(i_clk), .i_core_hold(o_core_hold), .o_sleep_exec(i_sleep_exec),
    .o_sleep_enable(i_sleep_enable), .o_sleep_kind_select(i_sleep_kind_select),
    .o_brownout_sleep_off_unlock(i_brownout_sleep_off_unlock), .o_brownout_sleep_off_wr(i_brownout_sleep_off_wr), .o_brownout_sleep_off_data(i_brownout_sleep_off_data));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic smc_clk_type exp_clk(input logic [2:0] k, input logic a);
    case (k)
      KIND_IDLE:  exp_clk = 5'h07;
      KIND_CONV:  exp_clk = {4'h1, a};
      KIND_PSAVE: exp_clk = 5'h01;
      KIND_XSTBY: exp_clk = {4'h0, a};
      default:    exp_clk = 5'h00;
    endcase
  endfunction

  function automatic int exp_start(input logic [2:0] k, input logic b);
    if (b && k[1]) return BODP;
    if (k == KIND_STBY || k == KIND_XSTBY) return 6;
    if (k[1]) return SUP;
    return 1;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic run_mode(input logic [2:0] k, input logic b);
    logic [31:0] r;
    int n;
    int c;
    r = xs();
    i_timer_async = r[0];
    // Converter mode runs with the converter on only when b is set, so both cases are met.
    i_converter_enabled = (k == KIND_CONV) ? b : r[1];
    @(negedge i_clk);
    i_core.do_sleep(k, 1'b1);
    if (k inside {3'h4, 3'h5}) begin
      chk("reserved", o_sleeping, 0);
      return;
    end
    chk("clk_en", o_clk_en, exp_clk(k, r[0]));
    chk("main_osc", o_main_osc_en, k inside {3'h0, 3'h1, 3'h6, 3'h7});
    chk("timer_osc", o_timer_osc_en, r[0] && !(k inside {KIND_PDOWN, KIND_STBY}));
    chk("det_en", o_brownout_det_en, !(b && k[1]));
    chk("conv_start", o_converter_start, k == KIND_CONV && i_converter_enabled);
    n = exp_start(k, b);
    if (k != KIND_IDLE) begin
      i_wake_src.other_io_irq = 1'b1;
      i_wake_src.ext_irq_zero = 1'b1;
      repeat (8) @(negedge i_clk);
      chk("masked", o_sleeping, 1);
      i_wake_src.other_io_irq = 1'b0;
      i_ext_irq_level = 2'b01;
    end else i_wake_src.other_io_irq = 1'b1;
    c = 0;
    while (o_sleeping !== 1'b0 && c < 30) begin
      @(negedge i_clk);
      c++;
    end
    chk("woke", o_sleeping, 0);
    c = 0;
    while (o_irq_service !== 1'b1 && c < 100) begin
      if (c == n - 1) chk("gated", o_clk_en, exp_clk(k, r[0]));
      if (c == n) chk("restored", o_clk_en, 5'h1f);
      chk("hold", o_core_hold, 1);
      @(negedge i_clk);
      c++;
    end
    chk("wake_len", c, n + 4);
    chk("det_on", o_brownout_det_en, 1);
    @(negedge i_clk);
    chk("resume", o_core_hold, 0);
    i_wake_src = '0;
    i_ext_irq_level = 2'b00;
    repeat (4) @(negedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    i_ext_irq_level = 2'b00;
    i_timer_async = 1'b0;
    i_converter_enabled = 1'b0;
    i_wake_src = '0;
    i_rst_src = '0;
    repeat (12) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk("rst_clk", o_clk_en, CLK_ALL_ON);
    chk("rst_brownout_sleep_off", o_brownout_sleep_off, 0);
    chk("rst_det", o_brownout_det_en, 1);
    i_core.do_sleep(KIND_PDOWN, 1'b0);
    chk("no_enable", o_sleeping, 0);
    for (int kk = 0; kk < 8; kk++) run_mode(3'(kk), 1'b0);
    i_core.brownout_sleep_off_seq(1'b0, 1, 1'b1);
    chk("brownout_sleep_off_nolock", o_brownout_sleep_off, 0);
    i_core.brownout_sleep_off_seq(1'b1, 6, 1'b1);
    chk("brownout_sleep_off_late", o_brownout_sleep_off, 0);
    i_core.brownout_sleep_off_seq(1'b1, 1, 1'b1);
    chk("brownout_sleep_off_set", o_brownout_sleep_off, 1);
    run_mode(KIND_PDOWN, 1'b1);
    run_mode(KIND_IDLE, 1'b1);
    run_mode(KIND_CONV, 1'b1);
    run_mode(KIND_XSTBY, 1'b1);
    i_core.do_sleep(KIND_PSAVE, 1'b1);
    i_rst_src.watchdog_reset = 1'b1;
    cnt = 0;
    while (o_restart_vector !== 1'b1 && cnt < 60) begin
      chk("no_service", o_irq_service, 0);
      @(negedge i_clk);
      cnt++;
    end
    chk("restart", o_restart_vector, 1);
    i_rst_src = '0;
    repeat (4) @(negedge i_clk);
    wrap_up();
  end

  // The run needs well under a thousand cycles; this bound only catches a hang.
  initial begin
    #(8 * 20000);
    err_total++;
    wrap_up();
  end
endmodule // tb_top
